//--- dv/pss_sequencer_tb_top.sv
// Purpose: self-checking bench for the program sequencer, return stack and indirect port
// Assumes: four-bank build judged in full, two-bank build on addressing and pointer view; memory is combinational
// Notes: the counter runs every cycle, so checks are taken relative to the counter seen
`timescale 1ns/1ns
module pss_sequencer_tb_top;
  logic clk, rst, jump, call, ret, drd, dwr, mwe, page, wload, psel, penable, pwrite;
  logic pready, pslverr;
  logic [11:0] instr;
  logic [4:0] daddr;
  logic [7:0] dwd, drdata, mwdata, mrdata, wval, paddr;
  logic [6:0] maddr;
  logic [5:0] maddr2;
  logic [7:0] drdata2;
  logic [9:0] pc;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] p2, p3;
  logic err;
  int n_errors, checks, cycles;

  // Memory contents differ from their address so a wrong redirect is visible
  assign mrdata = {1'b0, maddr} ^ 8'ha5;

  pss_sequencer #(.BANK_BITS(2)) uut (
    .CORE_CLK(clk), .RST(rst), .JUMP(jump), .CALL(call), .RET_LITERAL(ret),
    .INSTR_WORD(instr), .DATA_ADDR(daddr), .DATA_RD(drd), .DATA_WR(dwr),
    .DATA_WDATA(dwd), .DATA_RDATA(drdata), .MEM_ADDR(maddr), .MEM_WE(mwe),
    .MEM_WDATA(mwdata), .MEM_RDATA(mrdata), .PC(pc), .PAGE_PRESELECT(page),
    .W_LOAD(wload), .W_VALUE(wval), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr)
  );

  // Two-bank build shares all stimulus; only its MEM_ADDR and DATA_RDATA outputs are judged
  pss_sequencer #(.BANK_BITS(1)) uut_two_bank (
    .CORE_CLK(clk), .RST(rst), .JUMP(jump), .CALL(call), .RET_LITERAL(ret),
    .INSTR_WORD(instr), .DATA_ADDR(daddr), .DATA_RD(drd), .DATA_WR(dwr),
    .DATA_WDATA(dwd), .DATA_RDATA(drdata2), .MEM_ADDR(maddr2), .MEM_WE(),
    .MEM_WDATA(), .MEM_RDATA(mrdata), .PC(), .PAGE_PRESELECT(),
    .W_LOAD(), .W_VALUE(), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(), .PREADY(), .PSLVERR()
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task end_of_test();
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One instruction cycle: inputs change at the edge, results of the last edge read after
  task cyc(input logic [2:0] op, input logic [11:0] iw, input logic wr, input logic [4:0] a,
           input logic [7:0] wd);
    @(posedge clk);
    {jump, call, ret} <= op;
    instr <= iw;
    dwr <= wr;
    drd <= ~wr;
    daddr <= a;
    dwd <= wd;
    #1;
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task t_reset();
    chk("pc reset", 32'h3ff, {22'h0, pc});
    chk("page reset", 32'h0, {31'h0, page});
    cyc(3'b000, 12'h000, 1'b0, 5'h02, 8'h00);
    chk("pc wrap", 32'h000, {22'h0, pc});
    cyc(3'b000, 12'h000, 1'b0, 5'h02, 8'h00);
    chk("pc step", 32'h001, {22'h0, pc});
    chk("pc low read", 32'h01, {24'h0, drdata});
  endtask

  task t_jump_page();
    apb(1'b1, 8'h08, 32'h20);
    cyc(3'b100, 12'h1a5, 1'b0, 5'h03, 8'h00);
    cyc(3'b000, 12'h000, 1'b0, 5'h03, 8'h00);
    chk("jump target", 32'h3a5, {22'h0, pc});
    chk("status page", 32'h20, {24'h0, drdata});
    cyc(3'b000, 12'h000, 1'b1, 5'h02, 8'hc3);
    cyc(3'b000, 12'h000, 1'b0, 5'h02, 8'h00);
    chk("pc low write", 32'h2c3, {22'h0, pc});
    apb(1'b1, 8'h00, 32'h5e);
    #1;
    chk("apb pc low write", 32'h25e, {22'h0, pc});
    apb(1'b0, 8'h0c, 32'h0);
    chk("apb pc read", 32'h25f, rd);
  endtask

  task t_stack();
    cyc(3'b010, 12'h045, 1'b0, 5'h02, 8'h00);
    cyc(3'b010, 12'h067, 1'b0, 5'h02, 8'h00);
    chk("call 1", 32'h245, {22'h0, pc});
    p2 = 10'h246;
    cyc(3'b010, 12'h089, 1'b0, 5'h02, 8'h00);
    chk("call 2", 32'h267, {22'h0, pc});
    p3 = 10'h268;
    cyc(3'b000, 12'h000, 1'b0, 5'h02, 8'h00);
    chk("call 3", 32'h289, {22'h0, pc});
    apb(1'b0, 8'h10, 32'h0);
    chk("levels after calls", {6'h0, p2, 6'h0, p3}, rd);
    cyc(3'b001, 12'h011, 1'b0, 5'h02, 8'h00);
    cyc(3'b001, 12'h022, 1'b0, 5'h02, 8'h00);
    chk("return 1", {22'h0, p3}, {22'h0, pc});
    chk("w value 1", 32'h111, {23'h0, wload, wval});
    cyc(3'b001, 12'h033, 1'b0, 5'h02, 8'h00);
    chk("return 2", {22'h0, p2}, {22'h0, pc});
    chk("w value 2", 32'h122, {23'h0, wload, wval});
    cyc(3'b000, 12'h000, 1'b0, 5'h02, 8'h00);
    chk("return 3", {22'h0, p2}, {22'h0, pc});
    chk("w value 3", 32'h133, {23'h0, wload, wval});
    cyc(3'b000, 12'h000, 1'b0, 5'h02, 8'h00);
    chk("w load ends", 32'h033, {23'h0, wload, wval});
    apb(1'b0, 8'h10, 32'h0);
    chk("levels after pops", {6'h0, p2, 6'h0, p2}, rd);
    cyc(3'b100, 12'h0f0, 1'b0, 5'h02, 8'h00);
    cyc(3'b010, 12'h0ab, 1'b0, 5'h02, 8'h00);
    cyc(3'b001, 12'h05a, 1'b0, 5'h02, 8'h00);
    chk("call after jump", 32'h2ab, {22'h0, pc});
    cyc(3'b000, 12'h000, 1'b0, 5'h02, 8'h00);
    chk("return after call", 32'h2f1, {22'h0, pc});
    chk("w value 4", 32'h15a, {23'h0, wload, wval});
  endtask

  task t_indirect();
    apb(1'b1, 8'h04, 32'h47);
    apb(1'b0, 8'h04, 32'h0);
    chk("pointer apb read", 32'hc7, rd);
    cyc(3'b000, 12'h000, 1'b0, 5'h00, 8'h00);
    chk("indirect address", 32'h47, {25'h0, maddr});
    chk("two-bank address", 32'h07, {26'h0, maddr2});
    chk("indirect read", {24'h0, 8'h47 ^ 8'ha5}, {24'h0, drdata});
    cyc(3'b000, 12'h000, 1'b1, 5'h00, 8'h3c);
    chk("indirect write", 32'h13c, {23'h0, mwe, mwdata});
    cyc(3'b000, 12'h000, 1'b0, 5'h04, 8'h00);
    chk("pointer read", 32'hc7, {24'h0, drdata});
    cyc(3'b000, 12'h000, 1'b1, 5'h04, 8'h20);
    cyc(3'b000, 12'h000, 1'b0, 5'h04, 8'h00);
    chk("pointer view", 32'ha0, {24'h0, drdata});
    chk("two-bank view", 32'he0, {24'h0, drdata2});
    cyc(3'b000, 12'h000, 1'b0, 5'h00, 8'h00);
    chk("self read", 32'h0, {24'h0, drdata});
    cyc(3'b000, 12'h000, 1'b1, 5'h00, 8'h55);
    chk("self write", 32'h0, {31'h0, mwe});
    cyc(3'b000, 12'h000, 1'b1, 5'h03, 8'h00);
    cyc(3'b000, 12'h000, 1'b0, 5'h03, 8'h00);
    chk("status write", 32'h0, {23'h0, page, drdata});
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
  endtask

  // Hang guard: the whole sequence needs well under a few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      end_of_test();
    end
  end

  initial begin
    n_errors = 0;
    checks = 0;
    cycles = 0;
    rst = 1'b1;
    {jump, call, ret, drd, dwr, psel, penable, pwrite} = 8'h00;
    instr = 12'h000;
    daddr = 5'h02;
    dwd = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_jump_page();
    t_stack();
    t_indirect();
    end_of_test();
  end
endmodule

//--- src/pss_pkg.sv
// Purpose: shared constants of the program sequencer, return stack and indirect port
// Assumes: one instruction executes per CORE_CLK edge; decode sits outside this block
// Notes: data-space and APB offsets are byte addresses
// Operation
// - Program counter advances by one each instruction unless an instruction loads it.
// - Jump loads program counter bits 8:0 from the instruction word.
// - Program counter bits 7:0 are readable and writable as a data register.
// - Jump, call or low-byte write takes counter bit 9 from page preselect bit.
// - Call or low-byte write loads bits 7:0 and always clears bit 8.
// - Any reset sets the program counter to the last program location.
// - After the reset-location instruction the counter wraps to zero and continues.
// - Any reset clears the page preselect bit, selecting page 0.
// - Return stack is two levels deep, twelve bits each.
// - Call moves level 1 into level 2, then pushes counter plus one.
// - Beyond two nested calls only the two newest return addresses survive.
// - Return-with-literal loads counter from level 1, then copies level 2 down.
// - Repeated returns keep supplying level 2, which a pop leaves unchanged.
// - Return-with-literal also loads the working register with its literal.
// - No overflow or underflow flag exists for the stack.
// - Indirect data port redirects to the address held in the indirect pointer.
// - Indirect read with pointer selecting the port itself returns 00h.
// - Indirect write with pointer selecting the port itself stores nothing.
// - Low five pointer bits select data address 00h to 1Fh.
// - Four-bank variant: pointer bits 6:5 select bank, bit 7 reads one.
// - Two-bank variant: pointer bit 5 selects bank, bits 7:6 read one.
// - Page preselect zero means page 0, one means page 1, 512 words each.
package pss_pkg;
  localparam int PC_WIDTH = 10;
  localparam int STACK_WIDTH = 12;
  localparam int ADDR_LOW_BITS = 5;
  localparam int PAGE_BIT = 5;
  localparam logic [9:0] PC_RESET = 10'h3ff;
  localparam logic [9:0] PC_PAGE_SIZE = 10'h200;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [7:0] IND_SELF_READ = 8'h00;
  // Data-space addresses
  localparam logic [4:0] DA_INDIRECT_PORT = 5'h00;
  localparam logic [4:0] DA_PROGRAM_COUNTER_LOW = 5'h02;
  localparam logic [4:0] DA_STATUS = 5'h03;
  localparam logic [4:0] DA_INDIRECT_POINTER = 5'h04;
  // APB byte offsets
  localparam logic [7:0] AO_PROGRAM_COUNTER_LOW = 8'h00;
  localparam logic [7:0] AO_INDIRECT_POINTER = 8'h04;
  localparam logic [7:0] AO_PAGE_CONTROL = 8'h08;
  localparam logic [7:0] AO_PROGRAM_COUNTER = 8'h0c;
  localparam logic [7:0] AO_STACK_LEVELS = 8'h10;
endpackage

//--- src/pss_return_stack.sv
// Purpose: two-level return-address stack
// Assumes: push and pop never both high in one cycle
// Notes: no depth tracking at all, so nothing can flag overflow or underflow
`timescale 1ns/1ns
module pss_return_stack #(
  parameter int WIDTH = pss_pkg::STACK_WIDTH
) (
  input wire logic clk,               // Core clock
  input wire logic rst,               // Synchronous reset, active high
  input wire logic push,              // Call executes
  input wire logic pop,               // Return executes
  input wire logic [WIDTH-1:0] value, // Return address to push
  output logic [WIDTH-1:0] level1,    // Top of stack
  output logic [WIDTH-1:0] level2     // Second level
);
  always_ff @(posedge clk) begin
    if (rst) begin
      level1 <= '0;
    end else if (push) begin
      level1 <= value;
    end else if (pop) begin
      level1 <= level2;
    end
  end

  // Oldest entry falls off on push; pop leaves level 2 alone
  always_ff @(posedge clk) begin
    if (rst) begin
      level2 <= '0;
    end else if (push) begin
      level2 <= level1;
    end
  end
endmodule

//--- src/pss_sequencer.sv
// Purpose: program counter, return stack and indirect data addressing of the core
// Assumes: decode supplies one-cycle strobes, at most one load strobe per cycle
// Notes: APB slave with one access cycle; data memory port is combinational
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ns
module pss_sequencer #(
  parameter int BANK_BITS = 2 // 2: four-bank variant, 1: two-bank variant
) (
  input wire logic CORE_CLK,                  // Instruction-cycle clock
  input wire logic RST,                       // Synchronous reset, active high
  input wire logic JUMP,                      // Jump instruction executes
  input wire logic CALL,                      // Call instruction executes
  input wire logic RET_LITERAL,               // Return-with-literal executes
  input wire logic [11:0] INSTR_WORD,         // Executing instruction word
  input wire logic [4:0] DATA_ADDR,           // File address field of instruction
  input wire logic DATA_RD,                   // Instruction reads the file register
  input wire logic DATA_WR,                   // Instruction writes its result
  input wire logic [7:0] DATA_WDATA,          // Result to write
  output logic [7:0] DATA_RDATA,              // Read value after redirection
  output logic [4+BANK_BITS:0] MEM_ADDR,      // Data memory address, bank on top
  output logic MEM_WE,                        // Data memory write strobe
  output logic [7:0] MEM_WDATA,               // Data memory write data
  input wire logic [7:0] MEM_RDATA,           // Data memory read data
  output logic [9:0] PC,                      // Program counter
  output logic PAGE_PRESELECT,                // Page preselect bit
  output logic W_LOAD,                        // Working register load pulse
  output logic [7:0] W_VALUE,                 // Literal for working register
  input wire logic PSEL,                      // APB select
  input wire logic PENABLE,                   // APB enable
  input wire logic PWRITE,                    // APB direction
  input wire logic [7:0] PADDR,               // APB byte address
  input wire logic [31:0] PWDATA,             // APB write data
  output logic [31:0] PRDATA,                 // APB read data
  output logic PREADY,                        // APB ready
  output logic PSLVERR                        // APB error on unmapped address
);
  localparam int PW = pss_pkg::PC_WIDTH;
  localparam int SW = pss_pkg::STACK_WIDTH;
  localparam int IMPL = pss_pkg::ADDR_LOW_BITS + BANK_BITS;

  logic [PW-1:0] pc;
  logic [PW-1:0] next_pc;
  logic [PW-1:0] pc_inc;
  logic page;
  logic [IMPL-1:0] pointer;
  logic [7:0] pointer_view;
  logic [SW-1:0] level1;
  logic [SW-1:0] level2;
  logic [SW-1:0] push_value;
  logic indirect;
  logic self_target;
  logic [4:0] eff_addr;
  logic [BANK_BITS-1:0] eff_bank;
  logic core_pcl_wr;
  logic core_status_wr;
  logic core_pointer_wr;
  logic apb_wr;
  logic apb_setup;
  logic apb_mapped;
  logic [31:0] apb_rd_value;
  logic w_load;
  logic [7:0] w_value;
  logic [31:0] prdata;
  logic pslverr;

  // Unimplemented pointer bits read as one
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pointer_view
      if (gi < IMPL) begin : g_impl
        assign pointer_view[gi] = pointer[gi];
      end else begin : g_unimpl
        assign pointer_view[gi] = 1'b1;
      end
    end
  endgenerate

  // Indirect redirection happens before any register decode
  assign indirect = (DATA_ADDR == pss_pkg::DA_INDIRECT_PORT);
  assign eff_addr = indirect ? pointer[4:0] : DATA_ADDR;
  assign eff_bank = pointer[IMPL-1:pss_pkg::ADDR_LOW_BITS];
  assign self_target = indirect && (pointer[4:0] == pss_pkg::DA_INDIRECT_PORT);

  assign core_pcl_wr = DATA_WR && (eff_addr == pss_pkg::DA_PROGRAM_COUNTER_LOW);
  assign core_status_wr = DATA_WR && (eff_addr == pss_pkg::DA_STATUS);
  assign core_pointer_wr = DATA_WR && (eff_addr == pss_pkg::DA_INDIRECT_POINTER);

  always_comb begin
    if (self_target) begin
      DATA_RDATA = pss_pkg::IND_SELF_READ;
    end else begin
      case (eff_addr)
        pss_pkg::DA_PROGRAM_COUNTER_LOW: DATA_RDATA = pc[7:0];
        pss_pkg::DA_STATUS: DATA_RDATA = 8'(page) << pss_pkg::PAGE_BIT;
        pss_pkg::DA_INDIRECT_POINTER: DATA_RDATA = pointer_view;
        default: DATA_RDATA = MEM_RDATA;
      endcase
    end
  end

  // A write that lands on the port itself stores nowhere
  assign MEM_ADDR = {eff_bank, eff_addr};
  assign MEM_WDATA = DATA_WDATA;
  assign MEM_WE = DATA_WR && !self_target && (eff_addr != pss_pkg::DA_PROGRAM_COUNTER_LOW)
                  && (eff_addr != pss_pkg::DA_STATUS)
                  && (eff_addr != pss_pkg::DA_INDIRECT_POINTER);

  // APB: registered read data, answer in the access phase
  assign apb_setup = PSEL && !PENABLE;
  assign apb_wr = PSEL && PENABLE && PWRITE && apb_mapped;
  assign PREADY = 1'b1;
  assign PRDATA = prdata;
  assign PSLVERR = pslverr;

  always_comb begin
    apb_mapped = 1'b1;
    apb_rd_value = 32'h0000_0000;
    case (PADDR)
      pss_pkg::AO_PROGRAM_COUNTER_LOW: apb_rd_value = {24'h000000, pc[7:0]};
      pss_pkg::AO_INDIRECT_POINTER: apb_rd_value = {24'h000000, pointer_view};
      pss_pkg::AO_PAGE_CONTROL: apb_rd_value = 32'(page) << pss_pkg::PAGE_BIT;
      pss_pkg::AO_PROGRAM_COUNTER: apb_rd_value = 32'(pc);
      pss_pkg::AO_STACK_LEVELS: apb_rd_value = {4'h0, level2, 4'h0, level1};
      default: apb_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata <= PWRITE ? 32'h0000_0000 : apb_rd_value;
      pslverr <= !apb_mapped;
    end
  end

  // Program counter: instruction loads win over an APB low-byte write
  assign pc_inc = pc + 10'h001;

  always_comb begin
    next_pc = pc_inc;
    if (JUMP) begin
      next_pc = {page, INSTR_WORD[8:0]};
    end else if (CALL) begin
      next_pc = {page, 1'b0, INSTR_WORD[7:0]};
    end else if (RET_LITERAL) begin
      next_pc = level1[PW-1:0];
    end else if (core_pcl_wr) begin
      next_pc = {page, 1'b0, DATA_WDATA};
    end else if (apb_wr && PADDR == pss_pkg::AO_PROGRAM_COUNTER_LOW) begin
      next_pc = {page, 1'b0, PWDATA[7:0]};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pc <= pss_pkg::PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  // Page preselect: core write wins over APB in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      page <= 1'b0;
    end else if (core_status_wr) begin
      page <= DATA_WDATA[pss_pkg::PAGE_BIT];
    end else if (apb_wr && PADDR == pss_pkg::AO_PAGE_CONTROL) begin
      page <= PWDATA[pss_pkg::PAGE_BIT];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pointer <= pss_pkg::POINTER_RESET[IMPL-1:0];
    end else if (core_pointer_wr) begin
      pointer <= DATA_WDATA[IMPL-1:0];
    end else if (apb_wr && PADDR == pss_pkg::AO_INDIRECT_POINTER) begin
      pointer <= PWDATA[IMPL-1:0];
    end
  end

  // Return stack; upper bits of each level stay zero with a ten-bit counter
  assign push_value = SW'(pc_inc);

  pss_return_stack #(
    .WIDTH(SW)
  ) u_stack (
    .clk(CORE_CLK),
    .rst(RST),
    .push(CALL && !JUMP),
    .pop(RET_LITERAL && !JUMP && !CALL),
    .value(push_value),
    .level1(level1),
    .level2(level2)
  );

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      w_load <= 1'b0;
      w_value <= 8'h00;
    end else begin
      w_load <= RET_LITERAL && !JUMP && !CALL;
      if (RET_LITERAL && !JUMP && !CALL) begin
        w_value <= INSTR_WORD[7:0];
      end
    end
  end

  assign PC = pc;
  assign PAGE_PRESELECT = page;
  assign W_LOAD = w_load;
  assign W_VALUE = w_value;

  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  logic no_load;
  assign no_load = !JUMP && !CALL && !RET_LITERAL && !core_pcl_wr && !apb_wr;

  property p_increment;
    no_load |=> pc == $past(pc) + 10'h001;
  endproperty
  a_increment: assert property (p_increment) else $error("pc did not advance");

  property p_jump;
    JUMP |=> pc == {$past(page), $past(INSTR_WORD[8:0])};
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");

  property p_call_target;
    CALL && !JUMP |=> pc[8] == 1'b0 && pc[9] == $past(page) && pc[7:0] == $past(INSTR_WORD[7:0]);
  endproperty
  a_call_target: assert property (p_call_target) else $error("call target wrong");

  property p_pcl_write;
    core_pcl_wr && !JUMP && !CALL && !RET_LITERAL
      |=> pc == {$past(page), 1'b0, $past(DATA_WDATA)};
  endproperty
  a_pcl_write: assert property (p_pcl_write) else $error("low byte load wrong");

  property p_reset;
    @(posedge CORE_CLK) disable iff (1'b0) RST |=> pc == 10'h3ff && !page;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  property p_rollover;
    @(posedge CORE_CLK) disable iff (1'b0)
      RST ##1 (!RST && no_load) |=> pc == 10'h000;
  endproperty
  a_rollover: assert property (p_rollover) else $error("no wrap after reset");

  property p_push;
    CALL && !JUMP |=> level1[PW-1:0] == $past(pc) + 10'h001 && level1[SW-1:PW] == '0
      && level2 == $past(level1);
  endproperty
  a_push: assert property (p_push) else $error("push wrong");

  sequence s_return;
    RET_LITERAL && !JUMP && !CALL;
  endsequence

  property p_pop;
    s_return |=> pc == $past(level1[PW-1:0]) && level1 == $past(level2) && $stable(level2);
  endproperty
  a_pop: assert property (p_pop) else $error("pop wrong");

  sequence s_call_then_return;
    (CALL && !JUMP) ##1 (RET_LITERAL && !JUMP && !CALL);
  endsequence

  property p_call_return;
    s_call_then_return |=> pc == $past(pc, 2) + 10'h001;
  endproperty
  a_call_return: assert property (p_call_return) else $error("return address lost");

  property p_literal;
    s_return |=> W_LOAD && W_VALUE == $past(INSTR_WORD[7:0]) ##1 !W_LOAD || $past(RET_LITERAL);
  endproperty
  a_literal: assert property (p_literal) else $error("literal not loaded");

  property p_self_read;
    DATA_RD && self_target |-> DATA_RDATA == 8'h00;
  endproperty
  a_self_read: assert property (p_self_read) else $error("self read not zero");

  property p_self_write;
    DATA_WR && self_target && !apb_wr |-> !MEM_WE ##1 $stable(pointer) && $stable(page);
  endproperty
  a_self_write: assert property (p_self_write) else $error("self write stored");

  property p_pointer_view;
    eff_addr == pss_pkg::DA_INDIRECT_POINTER
      |-> DATA_RDATA[7] && DATA_RDATA[4:0] == pointer[4:0];
  endproperty
  a_pointer_view: assert property (p_pointer_view) else $error("pointer view wrong");

  property p_indirect_addr;
    indirect |-> MEM_ADDR == {eff_bank, pointer[4:0]};
  endproperty
  a_indirect_addr: assert property (p_indirect_addr) else $error("redirect wrong");

  property p_pc_read;
    eff_addr == pss_pkg::DA_PROGRAM_COUNTER_LOW |-> DATA_RDATA == pc[7:0];
  endproperty
  a_pc_read: assert property (p_pc_read) else $error("pc low read wrong");

  property p_apb_pc_write;
    apb_wr && PADDR == pss_pkg::AO_PROGRAM_COUNTER_LOW && !JUMP && !CALL && !RET_LITERAL
      && !core_pcl_wr |=> pc == {$past(page), 1'b0, $past(PWDATA[7:0])};
  endproperty
  a_apb_pc_write: assert property (p_apb_pc_write) else $error("bus pc load wrong");

  property p_status_read;
    eff_addr == pss_pkg::DA_STATUS |-> DATA_RDATA == {2'b00, page, 5'h00};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_page_write;
    core_status_wr |=> page == $past(DATA_WDATA[pss_pkg::PAGE_BIT]);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page write lost");

  property p_direct_addr;
    !indirect |-> MEM_ADDR[4:0] == DATA_ADDR;
  endproperty
  a_direct_addr: assert property (p_direct_addr) else $error("direct address wrong");

  property p_indirect_write;
    DATA_WR && indirect && pointer[4:0] > pss_pkg::DA_INDIRECT_POINTER
      |-> MEM_WE && MEM_WDATA == DATA_WDATA;
  endproperty
  a_indirect_write: assert property (p_indirect_write) else $error("redirect write lost");

  property p_pointer_write;
    core_pointer_wr |=> pointer_view[4:0] == $past(DATA_WDATA[4:0]);
  endproperty
  a_pointer_write: assert property (p_pointer_write) else $error("pointer write lost");

  property p_stack_hold;
    !CALL && !RET_LITERAL |=> $stable(level1) && $stable(level2);
  endproperty
  a_stack_hold: assert property (p_stack_hold) else $error("stack moved unasked");

  property p_literal_pulse;
    W_LOAD |-> $past(RET_LITERAL) && W_VALUE == $past(INSTR_WORD[7:0]);
  endproperty
  a_literal_pulse: assert property (p_literal_pulse) else $error("stray literal load");
endmodule
